// file: bench/t16w_timer_tb.sv
// Purpose: Self-checking bench for the 16-bit timer control block.
// Assumes: Zero-wait APB slave; the timer stays stopped unless a test starts it.
// Notes: Every wait is bounded, and a watchdog ends a hung run.
`timescale 1ns/1ps
module t16w_timer_tb;
    import t16w_pkg::*;
    logic sys_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic cap_pin = 1'b0;
    logic ce = 1'b1;
    logic ext_pin = 1'b0;
    logic [31:0] prdata;
    logic pready, pslverr, wa, wb, ea, eb, ovf, capf, last_err;
    int error_cnt = 0;
    int n_compared = 0;
    // ----------------------------------------------------------------
    // Design and clock.
    // ----------------------------------------------------------------
    t16w_timer DUT (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .ce_i(ce), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .capture_input_pin_i(cap_pin), .external_clock_pin_i(ext_pin), .wave_out_a_o(wa),
        .wave_out_b_o(wb), .wave_en_a_o(ea), .wave_en_b_o(eb), .overflow_flag_o(ovf),
        .capture_flag_o(capf));
    // Free-running 40 MHz clock.
    initial begin
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    // ----------------------------------------------------------------
    // Shared tasks.
    // ----------------------------------------------------------------
    task automatic conclude();
        if (error_cnt == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // One APB transfer; the request is held until pready is seen high, for at most 40 cycles.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk_i);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk_i);
            n++;
        end while (pready !== 1'b1 && n < 40);
        q = prdata;
        last_err = pslverr;
        chk("pready wait", 32'h1, {31'h0, pready});
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk($sformatf("read %h", a), e, q);
    endtask
    // Six pin toggles four cycles apart: three edges of each polarity.
    task automatic toggle_ext();
        repeat (6) begin
            repeat (4) @(posedge sys_clk_i);
            ext_pin <= !ext_pin;
        end
        repeat (4) @(posedge sys_clk_i);
    endtask
    task automatic settle();
        repeat (2) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic pin(input logic v, input int n);
        @(posedge sys_clk_i);
        cap_pin <= v;
        repeat (n) @(posedge sys_clk_i);
    endtask
    // Counts high cycles of channel A over two PWM periods of ten cycles.
    task automatic duty(input int e);
        int h;
        h = 0;
        repeat (40) @(posedge sys_clk_i);
        // Sampled mid-cycle; an unknown level spoils the count on purpose.
        repeat (20) begin
            @(negedge sys_clk_i);
            h += (wa === 1'b1) ? 1 : ((wa === 1'b0) ? 0 : 100);
        end
        chk("duty a", e, h);
    endtask
    // ----------------------------------------------------------------
    // Scenarios.
    // ----------------------------------------------------------------
    task automatic t_reset();
        logic [31:0] q;
        rd(OFS_CTRL_A, 32'h0);
        rd(OFS_CTRL_B, 32'h0);
        rd(OFS_CNT_LO, 32'h0);
        chk("enables", 32'h0, {30'h0, ea, eb});
        apb(1'b0, 8'h20, 32'h0, q);
        chk("unmapped err", 32'h1, {31'h0, last_err});
        wr(OFS_CNT_HI, 32'h12);
        wr(OFS_CNT_LO, 32'h34);
        rd(OFS_CNT_LO, 32'h34);
        rd(OFS_CNT_HI, 32'h12);
    endtask
    task automatic t_modes();
        logic [3:0] m;
        logic np;
        for (int i = 0; i < 16; i++) begin
            m = i[3:0];
            np = (m == 4'd0) || (m == 4'd4) || (m == 4'd12) || (m == 4'd13);
            wr(OFS_CTRL_B, {27'h0, m[3:2], 3'h0});
            wr(OFS_CTRL_A, {30'h0, m[1:0]});
            settle();
            chk("en a code 0", 32'h0, {31'h0, ea});
            wr(OFS_CTRL_A, {24'h0, 6'h14, m[1:0]});
            settle();
            chk("en a code 1", {31'h0, np | m == 4'd15 | m == 4'd9}, {31'h0, ea});
            chk("en b code 1", {31'h0, np}, {31'h0, eb});
        end
    endtask
    // Forced matches with the timer stopped, then a refused one in fast PWM.
    task automatic t_force();
        wr(OFS_CTRL_B, 32'h0);
        wr(OFS_CTRL_A, 32'h40);
        wr(OFS_CTRL_A, 32'h48);
        settle();
        chk("force toggle a", 32'h1, {31'h0, wa});
        rd(OFS_CTRL_A, 32'h40);
        rd(OFS_FLAGS, 32'h0);
        // The strobe uses the output code already held, so the code is set first.
        wr(OFS_CTRL_A, 32'h30);
        wr(OFS_CTRL_A, 32'h34);
        wr(OFS_CTRL_A, 32'h80);
        wr(OFS_CTRL_A, 32'h88);
        settle();
        chk("force b a", 32'h2, {30'h0, wb, wa});
        wr(OFS_CTRL_B, 32'h18);
        wr(OFS_CTRL_A, 32'hC2);
        // Deliberately breaks the zero-force rule, to show that the strobe is refused.
        wr(OFS_CTRL_A, 32'hCA);
        settle();
        chk("force in pwm", 32'h0, {31'h0, wa});
    endtask
    task automatic t_capture();
        wr(OFS_CTRL_B, 32'h40);
        wr(OFS_CTRL_A, 32'h0);
        wr(OFS_FLAGS, 32'hF);
        pin(1'b1, 10);
        rd(OFS_CAPT, 32'h1234);
        rd(OFS_FLAGS, 32'h2);
        wr(OFS_FLAGS, 32'hF);
        pin(1'b0, 10);
        rd(OFS_FLAGS, 32'h0);
        wr(OFS_CTRL_B, 32'h80);
        pin(1'b1, 12);
        rd(OFS_FLAGS, 32'h0);
        pin(1'b0, 2);
        pin(1'b1, 12);
        rd(OFS_FLAGS, 32'h0);
        pin(1'b0, 12);
        rd(OFS_FLAGS, 32'h2);
        wr(OFS_FLAGS, 32'hF);
        wr(OFS_CAPT, 32'h100);
        wr(OFS_CTRL_B, 32'h58);
        pin(1'b1, 12);
        rd(OFS_FLAGS, 32'h0);
    endtask
    // Mode 14 with TOP 9: period of ten timer cycles, one cycle per tick.
    task automatic t_pwm();
        logic [31:0] q;
        wr(OFS_CNT_HI, 32'h0);
        wr(OFS_CNT_LO, 32'h0);
        wr(OFS_CAPT, 32'h9);
        wr(OFS_CMP_A, 32'h2);
        wr(OFS_CTRL_A, 32'h82);
        wr(OFS_CTRL_B, 32'h19);
        duty(6);
        apb(1'b0, OFS_FLAGS, 32'h0, q);
        chk("overflow flag", 32'h1, {31'h0, q[0]});
        wr(OFS_CTRL_A, 32'hC2);
        duty(14);
        wr(OFS_CMP_A, 32'h9);
        wr(OFS_CTRL_A, 32'h82);
        duty(20);
    endtask
    // Divide-by-8 over 800 cycles; one count of slack for start and stop.
    task automatic t_presc();
        logic [31:0] q;
        wr(OFS_CTRL_B, 32'h0);
        wr(OFS_CTRL_A, 32'h0);
        wr(OFS_CNT_HI, 32'h0);
        wr(OFS_CNT_LO, 32'h0);
        wr(OFS_CTRL_B, 32'h2);
        repeat (796) @(posedge sys_clk_i);
        wr(OFS_CTRL_B, 32'h0);
        apb(1'b0, OFS_CNT_LO, 32'h0, q);
        chk("div 8 count", 32'h1, {31'h0, q >= 32'd99 && q <= 32'd101});
    endtask
    // Pin clocking in both polarities, the clock-enable freeze, and blocked matches.
    task automatic t_ext();
        wr(OFS_CNT_HI, 32'h0);
        wr(OFS_CNT_LO, 32'h0);
        wr(OFS_CTRL_B, 32'h6);
        toggle_ext();
        rd(OFS_CNT_LO, 32'h3);
        wr(OFS_CTRL_B, 32'h7);
        toggle_ext();
        rd(OFS_CNT_LO, 32'h6);
        // One tick, fifty frozen cycles, then three ticks up to the stopping write.
        wr(OFS_CTRL_B, 32'h1);
        @(posedge sys_clk_i);
        ce <= 1'b0;
        @(negedge sys_clk_i);
        chk("pready frozen", 32'h0, {31'h0, pready});
        repeat (50) @(posedge sys_clk_i);
        ce <= 1'b1;
        wr(OFS_CTRL_B, 32'h0);
        rd(OFS_CNT_LO, 32'hA);
        wr(OFS_FLAGS, 32'hF);
        wr(OFS_CMP_A, 32'h20);
        wr(OFS_CNT_LO, 32'h20);
        wr(OFS_CTRL_B, 32'h1);
        rd(OFS_FLAGS, 32'h0);
        wr(OFS_CNT_LO, 32'h1F);
        settle();
        rd(OFS_FLAGS, 32'h8);
        wr(OFS_CTRL_B, 32'h0);
    endtask
    // ----------------------------------------------------------------
    // Main sequence and watchdog.
    // ----------------------------------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        t_reset();
        t_modes();
        t_force();
        t_capture();
        t_pwm();
        t_presc();
        t_ext();
        conclude();
    end
    // The tests need under 5000 cycles; four times that means a hang.
    initial begin
        repeat (20000) @(posedge sys_clk_i);
        error_cnt++;
        conclude();
    end
endmodule

// file: hdl/t16w_capture_filter.sv
// Purpose: Synchronises the capture pin and optionally filters it.
// Assumes: The pin is asynchronous to sys_clk_i.
// Notes: Filtered output changes only after a run of equal samples.
`timescale 1ns/1ps
module t16w_capture_filter #(
    parameter int SAMPLES = t16w_pkg::FILTER_SAMPLES
) (
    // Clock, reset and enable.
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // Pin and control.
    input wire logic pin_i,
    input wire logic filter_en_i,
    // Result.
    output logic level_o
);
    import t16w_pkg::*;

    // Elaboration check: the history needs at least two samples to shift.
    if (SAMPLES < 2) begin : g_bad_samples
        $error("SAMPLES must be at least 2");
    end

    typedef struct packed {
        logic [1:0] sync;
        logic [SAMPLES-1:0] hist;
        logic level;
    } t16w_filt_t;

    t16w_filt_t s, next_s;

    // ----------------------------------------------------------------
    // Two-stage synchroniser, then a shift history of settled samples.
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.sync = {s.sync[0], pin_i};
        next_s.hist = {s.hist[SAMPLES-2:0], s.sync[1]};
        if (!filter_en_i) begin
            next_s.level = s.sync[1];
        end else if (&s.hist) begin
            next_s.level = 1'b1;
        end else if (~|s.hist) begin
            next_s.level = 1'b0;
        end
    end

    // State register; clock enable freezes everything.
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    assign level_o = s.level;
endmodule

// file: hdl/t16w_pkg.sv
// Purpose: Shared constants for the 16-bit timer waveform and capture control.
// Assumes: APB slave with 32-bit data, one register per aligned word.
// Notes: Register offsets are byte addresses.
package t16w_pkg;
    // ----------------------------------------------------------------
    // Register map.
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL_A = 8'h00;
    localparam logic [7:0] OFS_CTRL_B = 8'h04;
    localparam logic [7:0] OFS_CNT_LO = 8'h08;
    localparam logic [7:0] OFS_CNT_HI = 8'h0C;
    localparam logic [7:0] OFS_CMP_A = 8'h10;
    localparam logic [7:0] OFS_CMP_B = 8'h14;
    localparam logic [7:0] OFS_CAPT = 8'h18;
    localparam logic [7:0] OFS_FLAGS = 8'h1C;
    // ----------------------------------------------------------------
    // Field positions and reset values.
    // ----------------------------------------------------------------
    localparam int FORCE_A_BIT = 3;
    localparam int FORCE_B_BIT = 2;
    localparam int FILTER_EN_BIT = 7;
    localparam int EDGE_SEL_BIT = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    // ----------------------------------------------------------------
    // Counter limits and filter length.
    // ----------------------------------------------------------------
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [15:0] TOP_8BIT = 16'h00FF;
    localparam logic [15:0] TOP_9BIT = 16'h01FF;
    localparam logic [15:0] TOP_10BIT = 16'h03FF;
    localparam int FILTER_SAMPLES = 4;
    localparam int PRESC_BITS = 10;
    // Waveform mode classes.
    typedef enum logic [3:0] {
        K_NPWM = 4'h1,
        K_FAST = 4'h2,
        K_PC = 4'h4,
        K_PFC = 4'h8
    } t16w_kind_t;
endpackage

// file: hdl/t16w_timer.sv
// Purpose: 16-bit timer control: waveform modes, compare outputs,
//          capture, prescaler and byte-wise counter access over APB.
// Assumes: Pins are asynchronous; APB is on sys_clk_i.
// Notes: Overview of operation follows.
`timescale 1ns/1ps
module t16w_timer (
    // Clock, reset and enable.
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic ce_i,
    // APB slave.
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // Pins.
    input wire logic capture_input_pin_i,
    input wire logic external_clock_pin_i,
    output logic wave_out_a_o,
    output logic wave_out_b_o,
    output logic wave_en_a_o,
    output logic wave_en_b_o,
    // Status levels.
    output logic overflow_flag_o,
    output logic capture_flag_o
);
    import t16w_pkg::*;

    typedef struct packed {
        logic [1:0] com_a;
        logic [1:0] com_b;
        logic [3:0] wgm;
        logic filt_en;
        logic edge_sel;
        logic [2:0] csel;
        logic [15:0] cnt;
        logic [15:0] ocr_a;
        logic [15:0] ocr_b;
        logic [15:0] buf_a;
        logic [15:0] buf_b;
        logic [15:0] cap;
        logic [7:0] temp;
        logic down;
        logic wave_a;
        logic wave_b;
        logic blk;
        logic ovf_f;
        logic cap_f;
        logic cma_f;
        logic cmb_f;
        logic cap_prev;
        logic [PRESC_BITS-1:0] presc;
        logic [2:0] ext;
        logic [31:0] rdata;
        logic err;
    } t16w_state_t;

    t16w_state_t s, next_s;
    logic cap_level;

    // ----------------------------------------------------------------
    // Mode decoding helpers.
    // ----------------------------------------------------------------
    function automatic t16w_kind_t kind_of(input logic [3:0] w);
        unique case (w)
            4'd1, 4'd2, 4'd3, 4'd10, 4'd11: kind_of = K_PC;
            4'd5, 4'd6, 4'd7, 4'd14, 4'd15: kind_of = K_FAST;
            4'd8, 4'd9: kind_of = K_PFC;
            default: kind_of = K_NPWM; // Mode 13 is reserved; runs as normal.
        endcase
    endfunction

    function automatic logic cap_is_top(input logic [3:0] w);
        cap_is_top = (w == 4'd8) || (w == 4'd10) || (w == 4'd12) || (w == 4'd14);
    endfunction

    // Next output level for one channel given the events of this tick.
    function automatic logic wave_next(input logic cur, input logic [1:0] com,
                                       input t16w_kind_t k, input logic tog_ok,
                                       input logic hit, input logic bot,
                                       input logic up);
        wave_next = cur;
        if (k == K_NPWM) begin
            if (hit) begin
                wave_next = (com == 2'b01) ? !cur : com[0];
            end
        end else if (com == 2'b01) begin
            if (hit && tog_ok) begin
                wave_next = !cur;
            end
        end else if (com[1] && k == K_FAST) begin
            if (bot) begin
                wave_next = !com[0];
            end
            if (hit) begin
                wave_next = com[0];
            end
        end else if (com[1]) begin
            if (hit) begin
                wave_next = up ? com[0] : !com[0];
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Capture pin conditioning.
    // ----------------------------------------------------------------
    t16w_capture_filter #(
        .SAMPLES(FILTER_SAMPLES)
    ) u_filter (
        .sys_clk_i(sys_clk_i),
        .rstn_i(rstn_i),
        .ce_i(ce_i),
        .pin_i(capture_input_pin_i),
        .filter_en_i(s.filt_en),
        .level_o(cap_level)
    );

    // Decoded control and bus strobes.
    t16w_kind_t kind;
    logic [15:0] top;
    logic tick, bus_wr, setup, mapped, force_a, force_b;
    logic hit_a, hit_b, at_top, at_bot, wrap, cap_edge, ext_rise, ext_fall;

    always_comb begin
        kind = kind_of(s.wgm);
        unique case (s.wgm)
            4'd1, 4'd5: top = TOP_8BIT;
            4'd2, 4'd6: top = TOP_9BIT;
            4'd3, 4'd7: top = TOP_10BIT;
            4'd4, 4'd9, 4'd11, 4'd15: top = s.ocr_a;
            4'd8, 4'd10, 4'd12, 4'd14: top = s.cap;
            default: top = CNT_MAX;
        endcase
        setup = psel_i && !penable_i;
        bus_wr = psel_i && penable_i && pwrite_i;
        mapped = (paddr_i[7:5] == 3'b000) && (paddr_i[1:0] == 2'b00);
        // Forcing only acts in non-PWM modes.
        force_a = bus_wr && paddr_i == OFS_CTRL_A && pwdata_i[FORCE_A_BIT]
                  && kind == K_NPWM;
        force_b = bus_wr && paddr_i == OFS_CTRL_A && pwdata_i[FORCE_B_BIT]
                  && kind == K_NPWM;
        ext_fall = s.ext[2] && !s.ext[1];
        ext_rise = !s.ext[2] && s.ext[1];
        // Prescaler taps: a tick when the low divider bits are all ones.
        unique case (s.csel)
            3'd0: tick = 1'b0;
            3'd1: tick = 1'b1;
            3'd2: tick = &s.presc[2:0];
            3'd3: tick = &s.presc[5:0];
            3'd4: tick = &s.presc[7:0];
            3'd5: tick = &s.presc[9:0];
            3'd6: tick = ext_fall;
            default: tick = ext_rise;
        endcase
        at_top = s.cnt == top;
        at_bot = s.cnt == 16'h0000;
        wrap = tick && at_top && kind inside {K_NPWM, K_FAST};
        // Matches are blocked on the tick right after a counter write.
        hit_a = tick && !s.blk && s.cnt == s.ocr_a;
        hit_b = tick && !s.blk && s.cnt == s.ocr_b;
        cap_edge = s.edge_sel ? (cap_level && !s.cap_prev)
                              : (!cap_level && s.cap_prev);
    end

    // ----------------------------------------------------------------
    // Next-state logic: counter, waveform, capture and register file.
    // ----------------------------------------------------------------
    always_comb begin
        next_s = s;
        // Write one to clear; the hardware sets further down win over the clear.
        if (bus_wr && paddr_i == OFS_FLAGS) begin
            next_s.ovf_f = s.ovf_f && !pwdata_i[0];
            next_s.cap_f = s.cap_f && !pwdata_i[1];
            next_s.cmb_f = s.cmb_f && !pwdata_i[2];
            next_s.cma_f = s.cma_f && !pwdata_i[3];
        end
        next_s.presc = s.presc + PRESC_BITS'(1);
        // The edge detector compares the second and third synchroniser stages; the first is not used.
        next_s.ext = {s.ext[1], s.ext[0], external_clock_pin_i};
        next_s.cap_prev = cap_level;
        if (tick) begin
            next_s.blk = 1'b0;
        end
        // Counting sequence.
        if (tick) begin
            if (kind == K_NPWM || kind == K_FAST) begin
                next_s.cnt = at_top ? 16'h0000 : s.cnt + 16'h0001;
            end else if (!s.down) begin
                next_s.cnt = at_top ? s.cnt - 16'h0001 : s.cnt + 16'h0001;
                next_s.down = at_top;
            end else begin
                next_s.cnt = at_bot ? s.cnt + 16'h0001 : s.cnt - 16'h0001;
                next_s.down = !at_bot;
            end
        end
        // Overflow flag timing per mode class.
        if (kind == K_NPWM && tick && s.cnt == CNT_MAX) begin
            next_s.ovf_f = 1'b1;
        end
        if (kind == K_FAST && wrap) begin
            next_s.ovf_f = 1'b1;
        end
        if ((kind == K_PC || kind == K_PFC) && tick && s.down && at_bot) begin
            next_s.ovf_f = 1'b1;
        end
        // Double-buffered compare update points.
        if ((kind == K_FAST && wrap) || (kind == K_PC && tick && at_top && !s.down)
            || (kind == K_PFC && tick && at_bot && s.down)) begin
            next_s.ocr_a = s.buf_a;
            next_s.ocr_b = s.buf_b;
        end
        // Match flags; a forced compare never sets them.
        if (hit_a) begin
            next_s.cma_f = 1'b1;
        end
        if (hit_b) begin
            next_s.cmb_f = 1'b1;
        end
        // Waveform outputs; in fast PWM a compare at TOP is ignored for codes 10 and 11.
        next_s.wave_a = wave_next(s.wave_a, s.com_a, kind, s.wgm == 4'd15
            || (kind != K_FAST && (s.wgm == 4'd9 || s.wgm == 4'd14)),
            force_a || (hit_a && !(kind == K_FAST && at_top && s.com_a[1])),
            wrap, !s.down);
        next_s.wave_b = wave_next(s.wave_b, s.com_b, kind, 1'b0,
            force_b || (hit_b && !(kind == K_FAST && at_top && s.com_b[1])),
            wrap, !s.down);
        // Capture, or the TOP-reached flag when capture defines TOP.
        if (cap_is_top(s.wgm)) begin
            if (tick && at_top) begin
                next_s.cap_f = 1'b1;
            end
        end else if (cap_edge) begin
            next_s.cap = s.cnt;
            next_s.cap_f = 1'b1;
        end
        // Read data is staged in the setup phase.
        if (setup) begin
            next_s.err = !mapped;
            unique case (paddr_i)
                OFS_CTRL_A: next_s.rdata = {24'h000000, s.com_a, s.com_b, 2'b00, s.wgm[1:0]};
                OFS_CTRL_B: next_s.rdata = {24'h000000, s.filt_en, s.edge_sel, 1'b0,
                                            s.wgm[3:2], s.csel};
                OFS_CNT_LO: next_s.rdata = {24'h000000, s.cnt[7:0]};
                OFS_CNT_HI: next_s.rdata = {24'h000000, s.temp};
                OFS_CMP_A: next_s.rdata = {16'h0000, s.buf_a};
                OFS_CMP_B: next_s.rdata = {16'h0000, s.buf_b};
                OFS_CAPT: next_s.rdata = {16'h0000, s.cap};
                OFS_FLAGS: next_s.rdata = {28'h0000000, s.cma_f, s.cmb_f, s.cap_f, s.ovf_f};
                default: next_s.rdata = 32'h00000000;
            endcase
        end
        if (setup && !pwrite_i && paddr_i == OFS_CNT_LO) begin
            next_s.temp = s.cnt[15:8];
        end
        if (bus_wr) begin
            unique case (paddr_i)
                OFS_CTRL_A: begin
                    next_s.com_a = pwdata_i[7:6];
                    next_s.com_b = pwdata_i[5:4];
                    next_s.wgm[1:0] = pwdata_i[1:0];
                end
                OFS_CTRL_B: begin
                    next_s.filt_en = pwdata_i[FILTER_EN_BIT];
                    next_s.edge_sel = pwdata_i[EDGE_SEL_BIT];
                    next_s.wgm[3:2] = pwdata_i[4:3];
                    next_s.csel = pwdata_i[2:0];
                end
                OFS_CNT_LO: begin
                    next_s.cnt = {s.temp, pwdata_i[7:0]};
                    next_s.blk = 1'b1;
                end
                OFS_CNT_HI: next_s.temp = pwdata_i[7:0];
                OFS_CMP_A: begin
                    next_s.buf_a = pwdata_i[15:0];
                    if (kind == K_NPWM) begin
                        next_s.ocr_a = pwdata_i[15:0];
                    end
                end
                OFS_CMP_B: begin
                    next_s.buf_b = pwdata_i[15:0];
                    if (kind == K_NPWM) begin
                        next_s.ocr_b = pwdata_i[15:0];
                    end
                end
                OFS_CAPT: next_s.cap = pwdata_i[15:0];
                default: ;
            endcase
        end
    end

    // State register; the clock enable freezes all state.
    always_ff @(posedge sys_clk_i) begin
        if (!rstn_i) begin
            s <= '0;
        end else if (ce_i) begin
            s <= next_s;
        end
    end

    // ----------------------------------------------------------------
    // Outputs.
    // ----------------------------------------------------------------
    assign prdata_o = s.rdata;
    assign pready_o = ce_i;
    assign pslverr_o = s.err;
    assign wave_out_a_o = s.wave_a;
    assign wave_out_b_o = s.wave_b;
    // Code 01 connects both channels in non-PWM modes; in PWM modes only channel A, in modes 9 and 15.
    assign wave_en_a_o = (s.com_a == 2'b01) ? (s.wgm == 4'd15 || s.wgm == 4'd9
        || kind == K_NPWM) : (s.com_a != 2'b00);
    assign wave_en_b_o = (s.com_b == 2'b01) ? (kind == K_NPWM)
        : (s.com_b != 2'b00);
    assign overflow_flag_o = s.ovf_f;
    assign capture_flag_o = s.cap_f;

    // ----------------------------------------------------------------
    // Checks.
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rstn_i);

    chk_force_read_zero: assert property (ce_i && setup && !pwrite_i && paddr_i == OFS_CTRL_A
        |=> prdata_o[3:2] == 2'b00) else $error("force bits read nonzero");
    chk_off_no_drive: assert property (s.com_a == 2'b00 |-> !wave_en_a_o)
        else $error("channel A driven with code 00");
    chk_fast_b_toggle: assert property (kind == K_FAST && s.com_b == 2'b01 |-> !wave_en_b_o)
        else $error("channel B connected in fast PWM code 01");
    chk_cap_top_hold: assert property (ce_i && cap_is_top(s.wgm) && !bus_wr
        |=> $stable(s.cap)) else $error("capture moved while defining TOP");
    chk_write_blocks: assert property (ce_i && tick && s.blk && !s.cma_f && !bus_wr
        |=> !s.cma_f) else $error("match not blocked after count write");
    chk_stop_holds: assert property (ce_i && s.csel == 3'd0 && !bus_wr
        |=> $stable(s.cnt)) else $error("counter moved while stopped");
    chk_normal_ovf: assert property (ce_i && s.wgm == 4'd0 && tick && s.cnt == CNT_MAX
        && !bus_wr |=> s.ovf_f && s.cnt == 16'h0000) else $error("no overflow at MAX");
    chk_pc_turn: assert property (ce_i && s.wgm == 4'd1 && tick && !s.down
        && s.cnt == TOP_8BIT && !bus_wr |=> s.down && s.cnt == 16'h00FE)
        else $error("phase-correct turn missed");
endmodule
